/* ebc_bus_cycle.sv */
// external bus cycle sequencer: five programmable phases per cycle
// assumes timing words and requests come from logic on mclk_i
//
// Contract
// RQ1: phases run AB, C, D, E, F in order
// RQ2: phase lengths from selected chip select timing
// RQ3: setup 1-2 cycles, plus 0-3 on window change
// RQ4: command 0-3 cycles, access 1-32 cycles
// RQ5: write setup or turnaround 0-1 cycle
// RQ6: hold phase 0-3 cycles
// RQ7: ready input may stretch access when enabled
// RQ8: reference clock only with system source, driver
// RQ9: stretched access ends on sampled ready after minimum
`include "ebc_regs.svh"
`default_nettype none

module ebc_bus_cycle #(
    parameter int NCS    = 4,
    parameter int ADDR_W = 24,
    parameter int WIN_W  = 8
) (
    // clock and reset
    input  wire logic                    mclk_i,
    input  wire logic                    rstn_i,
    // per chip select timing control words
    input  wire logic [NCS*`EBC_CFG_W-1:0] chip_select_timing_control_i,
    // cycle request
    input  wire logic                    req_i,
    input  wire logic [$clog2(NCS)-1:0]  cs_i,
    input  wire logic [ADDR_W-1:0]       addr_i,
    input  wire logic                    wr_i,
    // external ready pin, active low
    input  wire logic                    ready_n_i,
    // reference clock control
    input  wire logic                    clk_src_sys_i,
    input  wire logic                    hs_drv_en_i,
    // cycle status and bus outputs
    output logic                         idle_o,
    output logic [4:0]                   phase_o,
    output logic                         done_o,
    output logic [$clog2(NCS)-1:0]       cs_o,
    output logic [ADDR_W-1:0]            addr_o,
    output logic                         wr_o,
    // reference clock output
    output logic                         reference_clock_output_o
);

    localparam int CSW = $clog2(NCS);
    logic rst_meta_reg;
    logic rst_sync_n;
    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_n   <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_n   <= rst_meta_reg;
        end
    end

    logic ready_n_f;
    ebc_sync #(
        .RST_VAL (1'b1)
    ) u_ready_sync (
        .clk_i   (mclk_i),
        .rstn_i  (rst_sync_n),
        .pin_i   (ready_n_i),
        .level_o (ready_n_f)
    );
    logic [`EBC_CFG_W-1:0] sel_cfg;
    assign sel_cfg = chip_select_timing_control_i[cs_i*`EBC_CFG_W +: `EBC_CFG_W]; // RQ2
    ebc_pkg::ebc_state_t    state_reg;
    ebc_pkg::ebc_state_t    state_next;
    logic [`EBC_CNT_W-1:0]  cnt_reg;
    logic [`EBC_CNT_W-1:0]  cnt_next;
    logic [`EBC_CFG_W-1:0]  cfg_reg;
    logic [`EBC_CFG_W-1:0]  cfg_next;
    logic [2:0]             ab_len_reg;
    logic [2:0]             ab_len_next;
    logic [WIN_W-1:0]       win_reg;
    logic [WIN_W-1:0]       win_next;
    logic                   win_vld_reg;
    logic                   win_vld_next;
    logic [CSW-1:0]         cs_reg;
    logic [CSW-1:0]         cs_next;
    logic [ADDR_W-1:0]      addr_reg;
    logic [ADDR_W-1:0]      addr_next;
    logic                   wr_reg;
    logic                   wr_next;
    logic                   done_reg;
    logic                   done_next;
    logic                   refclk_reg;
    logic                   refclk_next;
    logic [1:0]            cmd_len;
    logic                  wsu_len;
    logic [`EBC_CNT_W-1:0] acc_len;
    logic [1:0]            hold_len;
    logic                  rdy_en;
    logic                  start;
    logic                  win_change;
    logic [2:0]            ab_new;
    assign cmd_len  = cfg_reg[`EBC_CMD_LSB +: 2];
    assign wsu_len  = cfg_reg[`EBC_WSU_BIT];
    assign acc_len  = {1'b0, cfg_reg[`EBC_ACC_LSB +: `EBC_ACC_W]} + 6'h01; // RQ4
    assign hold_len = cfg_reg[`EBC_HOLD_LSB +: 2];
    assign rdy_en   = cfg_reg[`EBC_RDY_EN_BIT];
    assign start    = req_i && (state_reg == ebc_pkg::EBC_IDLE);
    // first cycle after reset counts as a window change
    assign win_change = !win_vld_reg || (win_reg != addr_i[ADDR_W-1 -: WIN_W]);
    assign ab_new     = {2'b00, sel_cfg[`EBC_AB_BASE_BIT]} + 3'h1
                      + (win_change ? {1'b0, sel_cfg[`EBC_WIN_EXT_LSB +: 2]} : 3'h0); // RQ3

    always_comb
    begin
        state_next   = state_reg;
        cnt_next     = cnt_reg;
        cfg_next     = cfg_reg;
        ab_len_next  = ab_len_reg;
        win_next     = win_reg;
        win_vld_next = win_vld_reg;
        cs_next      = cs_reg;
        addr_next    = addr_reg;
        wr_next      = wr_reg;
        done_next    = 1'b0;
        unique case (state_reg)
            ebc_pkg::EBC_IDLE:
            begin
                if (start)
                begin
                    cfg_next     = sel_cfg; // RQ2
                    ab_len_next  = ab_new;
                    cnt_next     = {3'h0, ab_new} - 6'h01; // RQ3
                    win_next     = addr_i[ADDR_W-1 -: WIN_W];
                    win_vld_next = 1'b1;
                    cs_next      = cs_i;
                    addr_next    = addr_i;
                    wr_next      = wr_i;
                    state_next   = ebc_pkg::EBC_AB; // RQ1
                end
            end
            ebc_pkg::EBC_AB, ebc_pkg::EBC_C, ebc_pkg::EBC_D:
            begin
                if (cnt_reg != 6'h00)
                begin
                    cnt_next = cnt_reg - 6'h01;
                end
                else if (state_reg == ebc_pkg::EBC_AB && cmd_len != 2'h0)
                begin
                    state_next = ebc_pkg::EBC_C; // RQ1
                    cnt_next   = {4'h0, cmd_len} - 6'h01; // RQ4
                end
                else if (state_reg != ebc_pkg::EBC_D && wsu_len)
                begin
                    state_next = ebc_pkg::EBC_D; // RQ5
                    cnt_next   = 6'h00;
                end
                else
                begin
                    state_next = ebc_pkg::EBC_E; // RQ1
                    cnt_next   = acc_len - 6'h01; // RQ4
                end
            end
            ebc_pkg::EBC_E:
            begin
                if (cnt_reg != 6'h00)
                begin
                    cnt_next = cnt_reg - 6'h01;
                end
                else if (!rdy_en || !ready_n_f) // RQ7 RQ9
                begin
                    if (hold_len != 2'h0)
                    begin
                        state_next = ebc_pkg::EBC_F; // RQ6
                        cnt_next   = {4'h0, hold_len} - 6'h01;
                    end
                    else
                    begin
                        state_next = ebc_pkg::EBC_IDLE;
                        done_next  = 1'b1;
                    end
                end
            end
            ebc_pkg::EBC_F:
            begin
                if (cnt_reg != 6'h00)
                begin
                    cnt_next = cnt_reg - 6'h01;
                end
                else
                begin
                    state_next = ebc_pkg::EBC_IDLE; // RQ6
                    done_next  = 1'b1;
                end
            end
            default:
            begin
                state_next = ebc_pkg::EBC_IDLE;
            end
        endcase
    end

    // divided by two so the pin copy can come from a flop
    always_comb
    begin
        refclk_next = (clk_src_sys_i && hs_drv_en_i) ? !refclk_reg : 1'b0; // RQ8
    end

    always_ff @(posedge mclk_i or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            state_reg   <= ebc_pkg::EBC_IDLE;
            cnt_reg     <= 6'h00;
            cfg_reg     <= '0;
            ab_len_reg  <= 3'h1;
            win_reg     <= '0;
            win_vld_reg <= 1'b0;
            cs_reg      <= '0;
            addr_reg    <= '0;
            wr_reg      <= 1'b0;
            done_reg    <= 1'b0;
            refclk_reg  <= 1'b0;
        end
        else
        begin
            state_reg   <= state_next;
            cnt_reg     <= cnt_next;
            cfg_reg     <= cfg_next;
            ab_len_reg  <= ab_len_next;
            win_reg     <= win_next;
            win_vld_reg <= win_vld_next;
            cs_reg      <= cs_next;
            addr_reg    <= addr_next;
            wr_reg      <= wr_next;
            done_reg    <= done_next;
            refclk_reg  <= refclk_next;
        end
    end

    assign idle_o                   = state_reg[0];
    assign phase_o                  = state_reg[5:1];
    assign done_o                   = done_reg;
    assign cs_o                     = cs_reg;
    assign addr_o                   = addr_reg;
    assign wr_o                     = wr_reg;
    assign reference_clock_output_o = refclk_reg;

    // helper: cycles spent in the current phase, saturating
    logic [`EBC_CNT_W-1:0] ph_cnt_reg;

    always_ff @(posedge mclk_i or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            ph_cnt_reg <= 6'h01;
        else if (state_next != state_reg)
            ph_cnt_reg <= 6'h01;
        else if (ph_cnt_reg != `EBC_CNT_MAX)
            ph_cnt_reg <= ph_cnt_reg + 6'h01;
    end

    phase_order_a: assert property (@(posedge mclk_i) disable iff (!rst_sync_n) // RQ1
        (state_reg == ebc_pkg::EBC_AB) |=> (state_reg inside
            {ebc_pkg::EBC_AB, ebc_pkg::EBC_C, ebc_pkg::EBC_D, ebc_pkg::EBC_E}))
        else $error("bus phase left address setup out of order");
    cfg_latch_a: assert property (@(posedge mclk_i) disable iff (!rst_sync_n) // RQ2
        start |=> (cfg_reg == $past(sel_cfg)))
        else $error("timing word of selected chip select not taken");
    ab_len_a: assert property (@(posedge mclk_i) disable iff (!rst_sync_n) // RQ3
        (state_reg == ebc_pkg::EBC_AB && state_next != ebc_pkg::EBC_AB)
            |-> (ph_cnt_reg == {3'h0, ab_len_reg} && ab_len_reg >= 3'h1 && ab_len_reg <= 3'h5))
        else $error("address setup length wrong");
    cmd_len_a: assert property (@(posedge mclk_i) disable iff (!rst_sync_n) // RQ4
        (state_reg == ebc_pkg::EBC_C && state_next != ebc_pkg::EBC_C)
            |-> (ph_cnt_reg == {4'h0, cmd_len}))
        else $error("command delay length wrong");
    acc_min_a: assert property (@(posedge mclk_i) disable iff (!rst_sync_n) // RQ4
        (state_reg == ebc_pkg::EBC_E && state_next != ebc_pkg::EBC_E)
            |-> (rdy_en ? ph_cnt_reg >= acc_len : ph_cnt_reg == acc_len))
        else $error("access phase length wrong");
    wsu_len_a: assert property (@(posedge mclk_i) disable iff (!rst_sync_n) // RQ5
        (state_reg != ebc_pkg::EBC_D) ##1 (state_reg == ebc_pkg::EBC_D)
            |=> (state_reg == ebc_pkg::EBC_E))
        else $error("write setup phase not one cycle");
    hold_len_a: assert property (@(posedge mclk_i) disable iff (!rst_sync_n) // RQ6
        (state_reg == ebc_pkg::EBC_F && state_next != ebc_pkg::EBC_F)
            |-> (ph_cnt_reg == {4'h0, hold_len} && done_next))
        else $error("hold phase length wrong");
    ready_wait_a: assert property (@(posedge mclk_i) disable iff (!rst_sync_n) // RQ7 RQ9
        (state_reg == ebc_pkg::EBC_E && rdy_en && ready_n_f) |=> (state_reg == ebc_pkg::EBC_E))
        else $error("access ended without ready");
    refclk_gate_a: assert property (@(posedge mclk_i) disable iff (!rst_sync_n) // RQ8
        !(clk_src_sys_i && hs_drv_en_i) |=> !reference_clock_output_o)
        else $error("reference clock driven while disabled");

endmodule

`default_nettype wire

/* ebc_pkg.sv */
// types shared by the external bus cycle sequencer
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none

package ebc_pkg;

    typedef enum logic [5:0] {
        EBC_IDLE = 6'b00_0001,
        EBC_AB   = 6'b00_0010,
        EBC_C    = 6'b00_0100,
        EBC_D    = 6'b00_1000,
        EBC_E    = 6'b01_0000,
        EBC_F    = 6'b10_0000
    } ebc_state_t;

endpackage

`default_nettype wire

/* ebc_ready_model.sv */
// ready model for the external module on the bus
// assumes access_i is the sequencer's access phase flag on mclk_i
`default_nettype none

module ebc_ready_model (
    // clock
    input  wire logic        mclk_i,
    // access phase and answer delay in cycles
    input  wire logic        access_i,
    input  wire logic [31:0] delay_i,
    // ready pin, active low, pulled up when released
    output logic             ready_n_o
);
    timeunit 1ns;
    timeprecision 1ps;

    int cnt = 0;

    initial ready_n_o = 1'b1;

    // held low to the end of access, well past the three cycle filter
    always @(posedge mclk_i)
    begin
        cnt       <= access_i ? cnt + 1 : 0;
        ready_n_o <= !(access_i && cnt >= delay_i);
    end
endmodule

`default_nettype wire

/* ebc_regs.svh */
// field positions of the per chip select timing control word
// assumes one word of EBC_CFG_W bits per chip select, packed low first
`ifndef EBC_REGS_SVH
`define EBC_REGS_SVH

`define EBC_CFG_W        14
`define EBC_AB_BASE_BIT  0
`define EBC_WIN_EXT_LSB  1
`define EBC_CMD_LSB      3
`define EBC_WSU_BIT      5
`define EBC_ACC_LSB      6
`define EBC_HOLD_LSB     11
`define EBC_RDY_EN_BIT   13
`define EBC_ACC_W        5
`define EBC_CNT_W        6
`define EBC_CNT_MAX      6'h3F

`endif

/* ebc_sync.sv */
// three flop synchroniser with agreement filter for a pin input
// assumes the input is asynchronous to clk_i
`default_nettype none

module ebc_sync #(
    parameter logic RST_VAL = 1'b1
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rstn_i,
    // pin and filtered level
    input  wire logic pin_i,
    output logic      level_o
);

    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic level_reg;
    logic level_next;

    // level only moves once the second and third stage agree
    always_comb
    begin
        level_next = (s2_reg == s3_reg) ? s3_reg : level_reg;
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            s1_reg    <= RST_VAL;
            s2_reg    <= RST_VAL;
            s3_reg    <= RST_VAL;
            level_reg <= RST_VAL;
        end
        else
        begin
            s1_reg    <= pin_i;
            s2_reg    <= s1_reg;
            s3_reg    <= s2_reg;
            level_reg <= level_next;
        end
    end

    assign level_o = level_reg;

endmodule

`default_nettype wire

/* tb_top.sv */
// bench for the external bus cycle sequencer
// assumes ebc_bus_cycle with default parameters and the ready model
`include "ebc_regs.svh"
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic        mclk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic [55:0] cfg = '0;
    logic        req = 1'b0;
    logic [1:0]  cs = 2'h0;
    logic [23:0] addr = 24'h00_0000;
    logic        wr = 1'b0;
    logic        src = 1'b0;
    logic        drv = 1'b0;
    logic [31:0] rdy_dly = 32'h0000_03E7;
    logic        ready_n, idle, done, wr_q, refclk, prev;
    logic [4:0]  phase;
    logic [1:0]  cs_q;
    logic [23:0] addr_q;
    logic [7:0]  last_win = 8'h00;
    bit          first = 1'b1;
    int          err_count = 0;
    int          comparisons = 0;
    int          cyc = 0;
    int          len [5];

    ebc_bus_cycle ebc_bus_cycle_inst (
        .mclk_i                       (mclk_i),
        .rstn_i                       (rstn_i),
        .chip_select_timing_control_i (cfg),
        .req_i                        (req),
        .cs_i                         (cs),
        .addr_i                       (addr),
        .wr_i                         (wr),
        .ready_n_i                    (ready_n),
        .clk_src_sys_i                (src),
        .hs_drv_en_i                  (drv),
        .idle_o                       (idle),
        .phase_o                      (phase),
        .done_o                       (done),
        .cs_o                         (cs_q),
        .addr_o                       (addr_q),
        .wr_o                         (wr_q),
        .reference_clock_output_o     (refclk)
    );

    ebc_ready_model ebc_ready_model_inst (
        .mclk_i    (mclk_i),
        .access_i  (phase[3]),
        .delay_i   (rdy_dly),
        .ready_n_o (ready_n)
    );

    initial
    begin
        forever #5 mclk_i = ~mclk_i;
    end

    task automatic check(input bit ok, input string msg);
        comparisons++;
        if (!ok)
        begin
            err_count++;
            $display("MISMATCH at %0t: %s", $time, msg);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // field order: ready en, hold, access-1, write setup, command, extra, base
    function automatic logic [13:0] mk(int b, int x, int c, int d, int e, int f, int r);
        int e1;
        e1 = e - 1;
        return {r[0], f[1:0], e1[4:0], d[0], c[1:0], x[1:0], b[0]};
    endfunction

    // one bus cycle; access may exceed its minimum by lo..hi when ready waits
    task automatic run(input int c, input logic [13:0] w, input logic [23:0] a,
                       input logic wrt, input bit poke, input int lo, input int hi);
        int exp [5];
        int last;
        int n;
        exp[0] = w[`EBC_AB_BASE_BIT] + 1;
        if (first || a[23:16] != last_win)
            exp[0] = exp[0] + w[`EBC_WIN_EXT_LSB +: 2];
        exp[1] = w[`EBC_CMD_LSB +: 2];
        exp[2] = w[`EBC_WSU_BIT];
        exp[3] = w[`EBC_ACC_LSB +: `EBC_ACC_W] + 1;
        exp[4] = w[`EBC_HOLD_LSB +: 2];
        first = 1'b0;
        last_win = a[23:16];
        last = 0;
        n = 0;
        foreach (len[i]) len[i] = 0;
        cfg[c*`EBC_CFG_W +: `EBC_CFG_W] = w;
        cs = c[1:0];
        addr = a;
        wr = wrt;
        req = 1'b1;
        @(negedge mclk_i);
        while (idle !== 1'b1 && n < 200)
        begin
            check($onehot(phase), "phase not one hot");
            for (int i = 0; i < 5; i++)
            begin
                if (phase[i] === 1'b1)
                begin
                    len[i]++;
                    check(i >= last, "phase order");
                    last = i;
                end
            end
            // a request while busy must be ignored
            req = poke && phase[3] === 1'b1 && len[3] == 1;
            addr = req ? ~a : a;
            @(negedge mclk_i);
            n++;
        end
        check(n < 200, "bus cycle hung");
        check(done === 1'b1, "no done pulse");
        for (int i = 0; i < 5; i++)
            if (i != 3) check(len[i] == exp[i], "phase length");
        check(len[3] >= exp[3] + lo && len[3] <= exp[3] + hi, "access length");
        check(addr_q === a && cs_q === c[1:0] && wr_q === wrt, "request copy");
        $display("test cs %0d: %0d %0d %0d %0d %0d", c, len[0], len[1], len[2], len[3], len[4]);
    endtask

    always @(posedge mclk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            err_count++;
            print_verdict();
        end
    end

    initial
    begin
        repeat (20) @(negedge mclk_i);
        rstn_i = 1'b1;
        repeat (4) @(negedge mclk_i);
        // first cycle after reset counts as a window change; next ones back to back
        run(0, mk(0, 3, 1, 0, 2, 1, 0), 24'h12_3456, 1'b0, 1'b0, 0, 0);
        run(0, mk(0, 3, 1, 0, 2, 1, 0), 24'h12_0000, 1'b1, 1'b0, 0, 0);
        run(1, mk(1, 2, 3, 1, 32, 3, 0), 24'hA5_0001, 1'b1, 1'b0, 0, 0);
        run(2, mk(1, 0, 0, 0, 1, 0, 0), 24'h5A_FFFF, 1'b0, 1'b0, 0, 0);
        run(3, mk(0, 1, 2, 1, 8, 2, 0), 24'h5A_0002, 1'b1, 1'b1, 0, 0);
        rdy_dly = 32'h0000_0000;
        run(3, mk(0, 1, 0, 0, 8, 3, 1), 24'h33_0000, 1'b0, 1'b0, 0, 0);
        rdy_dly = 32'h0000_0014;
        run(3, mk(0, 1, 0, 0, 2, 3, 1), 24'h33_0004, 1'b1, 1'b0, 20, 25);
        rdy_dly = 32'h0000_03E7;
        for (int k = 0; k < 4; k++)
        begin
            src = k[0];
            drv = k[1];
            repeat (3) @(negedge mclk_i);
            prev = refclk;
            repeat (4)
            begin
                @(negedge mclk_i);
                check(k == 3 ? refclk === ~prev : refclk === 1'b0, "reference clock");
                prev = refclk;
            end
        end
        $display("test reference clock done");
        print_verdict();
    end
endmodule

`default_nettype wire
